// *** src/apo_top.sv ***
/*
 * Alarm evaluation and relay output control: 32 alarms in 4 groups,
 * one relay per group with selectable signal shape, energy pulse output,
 * tariff decode, pulse input counter, watchdog relay, LED and beeper.
 * Assumes all inputs are synchronous to clock and quantities are fresh
 * values that change slower than one full alarm scan (32 cycles).
 */
// Implementation choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Normal shape keeps the relay closed while the condition is unmet and opens it once met.
// - Inverse shape keeps the relay open while the condition is unmet and closes it once met.
// - Latched shape closes the relay on the condition and holds it until a software reset.
// - Pulse shape sends one pulse of the set length each time the condition becomes met; a rise during a pulse or its gap sends none.
// - Permanent shape holds the relay on or off as set, ignoring the condition.
// - The permanent on/off bit is writable by software for remote output control.
// - Relay pulse lengths below 10 ms are clamped up to 10 ms.
// - There are 32 alarms, alarm n belonging to group n/8 of 4 groups.
// - Each group holds a thermal time constant, an activation delay and a hysteresis.
// - Each alarm holds its quantity, instantaneous or demand choice, condition and threshold.
// - The energy pulse output gives the set pulses per unit of one counter, only in its tariff.
// - The two tariff inputs decode to one of four active tariffs.
// - The pulse input counts external pulses and is routed to one of four energy counters.
// - The watchdog relay is closed normally and opens on fault, supply loss or test.
// - The red LED blinks while any visual alarm is active.
// - The beeper sounds while an audible alarm is active until any key is pressed.
module apo_top
	import apo_pkg::*;
#(
	parameter int TICK_CYCLES = MS_CYCLES
) (
	input wire logic clock,
	input wire logic rstn,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	input wire logic [N_QTY*QW-1:0] meas_value,
	input wire logic [N_QTY*QW-1:0] max_demand_value,
	input wire logic [3:0] energy_unit,
	input wire logic [1:0] tariff_in,
	input wire logic pulse_in,
	input wire logic fault,
	input wire logic supply_ok,
	input wire logic key_press,
	output logic [N_GROUPS-1:0] relay_closed,
	output logic energy_pulse,
	output logic [3:0] tariff_active,
	output logic [3:0] pulse_to_counter,
	output logic watchdog_closed,
	output logic led_red,
	output logic beeper,
	output logic [N_GROUPS*QW-1:0] group_time_const,
	output logic irq
);
	logic [31:0] ctrl;
	logic [31:0] relay_cfg [N_GROUPS];
	logic [31:0] group_cfg [N_GROUPS];
	logic [QW-1:0] tconst [N_GROUPS];
	logic [31:0] energy_cfg;
	logic [4:0] alarm_index;
	logic [31:0] pulse_count;
	logic [INT_W-1:0] int_status;
	logic [INT_W-1:0] int_enable;
	logic [N_ALARMS-1:0] alarm_active;
	logic [N_ALARMS-1:0] visual_flag;
	logic [N_ALARMS-1:0] audible_flag;
	logic [4:0] scan;
	logic [4:0] scan_d;
	logic scan_valid;
	logic [31:0] tick_cnt;
	logic tick;
	logic [N_GROUPS-1:0] group_active;
	logic [N_GROUPS-1:0] group_rise;
	logic [N_GROUPS-1:0] latched;
	logic [N_GROUPS-1:0] latch_set;
	logic [N_GROUPS-1:0] relay_pulse;
	logic [N_GROUPS-1:0] next_relay;
	logic pulse_in_d;
	logic pulse_edge;
	logic [15:0] ep_pending;
	logic ep_trig;
	logic ep_busy;
	logic silenced;
	logic blink;
	logic [15:0] blink_cnt;
	logic wd_prev;
	logic [INT_W-1:0] int_events;

	function automatic logic [QW-1:0] pick(input logic [N_QTY*QW-1:0] vec, input logic [3:0] sel);
		pick = vec[sel*QW +: QW];
	endfunction : pick

	function automatic logic [15:0] clamp_len(input logic [15:0] len);
		clamp_len = (len < MIN_PULSE_MS) ? MIN_PULSE_MS : len;
	endfunction : clamp_len

	function automatic logic hit(input logic [7:0] a, input logic [7:0] base, input int i);
		hit = (a == base + 8'(4 * i));
	endfunction : hit

	apo_cfg_if #(.W(32), .AW(5)) cfg_port ();

	apo_cfg_mem #(.W(32), .D(N_ALARMS)) u_cfg_mem (
		.clock(clock),
		.port(cfg_port.store)
	);

	// Alarm configuration words are written through the index register
	assign cfg_port.we = wr && addr == REG_ALARM_CFG;
	assign cfg_port.waddr = alarm_index;
	assign cfg_port.wdata = wdata;
	assign cfg_port.raddr = scan;

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			tick_cnt <= 32'h0000_0000;
			tick <= 1'b0;
		end else begin
			tick <= (tick_cnt == 32'(TICK_CYCLES - 1));
			tick_cnt <= (tick_cnt == 32'(TICK_CYCLES - 1)) ? 32'h0000_0000 : tick_cnt + 32'h1;
		end
	end

	// Register writes; each configuration concern is a plain store
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			ctrl <= 32'h0000_0000;
			energy_cfg <= ENERGY_RESET;
			alarm_index <= 5'h00;
			int_enable <= '0;
			for (int i = 0; i < N_GROUPS; i++) begin
				relay_cfg[i] <= RELAY_RESET;
				group_cfg[i] <= 32'h0000_0000;
				tconst[i] <= 16'h0000;
			end
		end else if (wr) begin
			if (addr == REG_CTRL) begin
				ctrl <= wdata;
			end
			if (addr == REG_ENERGY_PULSE) begin
				energy_cfg <= wdata;
			end
			if (addr == REG_ALARM_INDEX) begin
				alarm_index <= wdata[4:0];
			end
			if (addr == REG_INT_ENABLE) begin
				int_enable <= wdata[INT_W-1:0];
			end
			for (int i = 0; i < N_GROUPS; i++) begin
				if (hit(addr, REG_RELAY_BASE, i)) begin
					relay_cfg[i] <= wdata;
				end
				if (hit(addr, REG_GROUP_BASE, i)) begin
					group_cfg[i] <= wdata;
				end
				if (hit(addr, REG_TCONST_BASE, i)) begin
					tconst[i] <= wdata[QW-1:0];
				end
			end
		end
	end

	// Scan one alarm per cycle; the store answers one cycle after the address
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			scan <= 5'h00;
			scan_d <= 5'h00;
			scan_valid <= 1'b0;
		end else begin
			scan <= scan + 5'h01;
			scan_d <= scan;
			scan_valid <= !cfg_port.we || cfg_port.waddr != scan;
		end
	end

	// Hysteresis applies only on the way out, so a noisy quantity cannot chatter
	always_ff @(posedge clock or negedge rstn) begin
		logic [31:0] c;
		logic [QW:0] q;
		logic [QW:0] thr;
		logic [QW:0] hy;
		logic met;
		if (!rstn) begin
			alarm_active <= '0;
			visual_flag <= '0;
			audible_flag <= '0;
		end else if (scan_valid) begin
			c = cfg_port.rdata;
			q = {1'b0, c[AC_MD] ? pick(max_demand_value, c[AC_QTY_LSB +: 4])
				: pick(meas_value, c[AC_QTY_LSB +: 4])};
			thr = {1'b0, c[AC_THR_LSB +: QW]};
			hy = {1'b0, group_cfg[scan_d[4:3]][LEN_LSB +: QW]};
			if (c[AC_ABOVE]) begin
				met = alarm_active[scan_d] ? (q + hy > thr) : (q > thr);
			end else begin
				met = alarm_active[scan_d] ? (q < thr + hy) : (q < thr);
			end
			alarm_active[scan_d] <= met;
			visual_flag[scan_d] <= c[AC_VISUAL];
			audible_flag[scan_d] <= c[AC_AUDIBLE];
		end
	end

	generate
		for (genvar g = 0; g < N_GROUPS; g++) begin : gen_group
			logic [15:0] dly_cnt;
			logic raw;
			logic act_d;
			apo_shape_type shape;
			assign raw = |alarm_active[g*8 +: 8];
			assign shape = apo_shape_type'(relay_cfg[g][RELAY_SHAPE_LSB +: 3]);
			assign group_time_const[g*QW +: QW] = tconst[g];

			always_ff @(posedge clock or negedge rstn) begin
				if (!rstn) begin
					dly_cnt <= 16'h0000;
					group_active[g] <= 1'b0;
				end else if (!raw) begin
					dly_cnt <= 16'h0000;
					group_active[g] <= 1'b0;
				end else if (dly_cnt >= group_cfg[g][15:0]) begin
					group_active[g] <= 1'b1;
				end else if (tick) begin
					dly_cnt <= dly_cnt + 16'h0001;
				end
			end

			always_ff @(posedge clock or negedge rstn) begin
				if (!rstn) begin
					act_d <= 1'b0;
					latched[g] <= 1'b0;
				end else begin
					act_d <= group_active[g];
					if (group_active[g] && shape == APO_LATCHED) begin
						latched[g] <= 1'b1;
					end else if (wr && addr == REG_LATCH_CLEAR && wdata[g]) begin
						latched[g] <= 1'b0;
					end
				end
			end
			assign group_rise[g] = group_active[g] && !act_d;
			assign latch_set[g] = group_active[g] && shape == APO_LATCHED && !latched[g];

			apo_pulse_gen u_relay_pulse (
				.clock(clock),
				.rstn(rstn),
				.tick(tick),
				.trigger(group_rise[g] && shape == APO_PULSE),
				.len(clamp_len(relay_cfg[g][LEN_LSB +: 16])),
				.busy(),
				.pulse(relay_pulse[g])
			);

			always_comb begin
				case (shape)
					APO_NORMAL: next_relay[g] = !group_active[g];
					APO_INVERSE: next_relay[g] = group_active[g];
					APO_LATCHED: next_relay[g] = latched[g] || group_active[g];
					APO_PULSE: next_relay[g] = relay_pulse[g];
					APO_PERMANENT: next_relay[g] = relay_cfg[g][RELAY_PERM_ON];
					default: next_relay[g] = 1'b0;
				endcase
			end
		end
	endgenerate

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			relay_closed <= '0;
		end else begin
			relay_closed <= next_relay;
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			tariff_active <= 4'h0;
		end else begin
			tariff_active <= 4'h1 << tariff_in;
		end
	end

	// Units arriving mid-train are queued, so a fast counter loses no pulses
	always_ff @(posedge clock or negedge rstn) begin
		logic add;
		if (!rstn) begin
			ep_pending <= 16'h0000;
			ep_trig <= 1'b0;
		end else begin
			add = energy_unit[energy_cfg[EP_CNT_LSB +: 2]]
				&& tariff_in == energy_cfg[EP_TARIFF_LSB +: 2];
			ep_trig <= !ep_busy && !ep_trig && ep_pending != 16'h0000;
			ep_pending <= ep_pending
				+ (add ? {8'h00, energy_cfg[EP_PPU_LSB +: 8]} : 16'h0000)
				- ((!ep_busy && !ep_trig && ep_pending != 16'h0000) ? 16'h0001 : 16'h0000);
		end
	end

	apo_pulse_gen u_energy_pulse (
		.clock(clock),
		.rstn(rstn),
		.tick(tick),
		.trigger(ep_trig),
		.len(clamp_len(energy_cfg[LEN_LSB +: 16])),
		.busy(ep_busy),
		.pulse(energy_pulse)
	);

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			pulse_in_d <= 1'b0;
			pulse_count <= 32'h0000_0000;
			pulse_to_counter <= 4'h0;
		end else begin
			pulse_in_d <= pulse_in;
			if (pulse_edge) begin
				pulse_count <= pulse_count + 32'h1;
			end
			pulse_to_counter <= pulse_edge ? 4'h1 << ctrl[CTRL_ROUTE_LSB +: 2] : 4'h0;
		end
	end
	assign pulse_edge = pulse_in && !pulse_in_d;

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			watchdog_closed <= 1'b0;
			wd_prev <= 1'b0;
		end else begin
			watchdog_closed <= !fault && supply_ok && !ctrl[CTRL_WD_TEST];
			wd_prev <= watchdog_closed;
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			blink_cnt <= 16'h0000;
			blink <= 1'b0;
			led_red <= 1'b0;
		end else begin
			if (tick) begin
				blink_cnt <= (blink_cnt == BLINK_MS - 16'h0001) ? 16'h0000 : blink_cnt + 16'h0001;
				if (blink_cnt == BLINK_MS - 16'h0001) begin
					blink <= !blink;
				end
			end
			led_red <= |(alarm_active & visual_flag) && blink;
		end
	end

	// Silence lasts until no audible alarm remains, then a new one sounds again
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			silenced <= 1'b0;
			beeper <= 1'b0;
		end else begin
			if (key_press) begin
				silenced <= 1'b1;
			end else if (!(|(alarm_active & audible_flag))) begin
				silenced <= 1'b0;
			end
			beeper <= |(alarm_active & audible_flag) && !silenced && !key_press;
		end
	end

	assign int_events = {wd_prev && !watchdog_closed, pulse_edge, latch_set, group_rise};

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			int_status <= '0;
		end else begin
			int_status <= int_events
				| (int_status & ~((wr && addr == REG_INT_CLEAR) ? wdata[INT_W-1:0] : '0));
		end
	end
	assign irq = |(int_status & int_enable);

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rdata <= 32'h0000_0000;
		end else begin
			rdata <= 32'h0000_0000;
			if (rd) begin
				case (addr)
					REG_CTRL: rdata <= ctrl;
					REG_STATE: rdata <= {21'h0, tariff_in, watchdog_closed, relay_closed,
						group_active};
					REG_INT_STATUS: rdata <= {22'h0, int_status};
					REG_INT_ENABLE: rdata <= {22'h0, int_enable};
					REG_PULSE_COUNT: rdata <= pulse_count;
					REG_ENERGY_PULSE: rdata <= energy_cfg;
					REG_ALARM_INDEX: rdata <= {27'h0, alarm_index};
					REG_ALARM_ACTIVE: rdata <= alarm_active;
					default: begin
						for (int i = 0; i < N_GROUPS; i++) begin
							if (hit(addr, REG_RELAY_BASE, i)) rdata <= relay_cfg[i];
							if (hit(addr, REG_GROUP_BASE, i)) rdata <= group_cfg[i];
							if (hit(addr, REG_TCONST_BASE, i)) rdata <= {16'h0, tconst[i]};
						end
					end
				endcase
			end
		end
	end
endmodule : apo_top
`default_nettype wire

// *** src/apo_pkg.sv ***
/*
 * Shared constants of the alarm and pulse output block: register map,
 * field positions, reset values, timing counts and the relay signal shapes.
 * Assumes a 100 MHz clock and a byte-addressed register port.
 */
package apo_pkg;
	localparam int CLK_PERIOD_NS = 10;
	localparam int MS_NS = 1000000;
	localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
	localparam logic [15:0] MIN_PULSE_MS = 16'h000a;
	localparam logic [15:0] BLINK_MS = 16'h01f4;
	localparam int N_ALARMS = 32;
	localparam int N_GROUPS = 4;
	localparam int N_QTY = 16;
	localparam int QW = 16;

	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATE = 8'h04;
	localparam logic [7:0] REG_INT_STATUS = 8'h08;
	localparam logic [7:0] REG_INT_ENABLE = 8'h0c;
	localparam logic [7:0] REG_INT_CLEAR = 8'h10;
	localparam logic [7:0] REG_LATCH_CLEAR = 8'h14;
	localparam logic [7:0] REG_PULSE_COUNT = 8'h18;
	localparam logic [7:0] REG_ENERGY_PULSE = 8'h1c;
	localparam logic [7:0] REG_ALARM_INDEX = 8'h20;
	localparam logic [7:0] REG_ALARM_CFG = 8'h24;
	localparam logic [7:0] REG_ALARM_ACTIVE = 8'h28;
	localparam logic [7:0] REG_RELAY_BASE = 8'h40;
	localparam logic [7:0] REG_GROUP_BASE = 8'h50;
	localparam logic [7:0] REG_TCONST_BASE = 8'h60;

	localparam int CTRL_WD_TEST = 0;
	localparam int CTRL_ROUTE_LSB = 1;
	localparam int RELAY_SHAPE_LSB = 0;
	localparam int RELAY_PERM_ON = 3;
	localparam int LEN_LSB = 16;
	localparam int EP_CNT_LSB = 0;
	localparam int EP_TARIFF_LSB = 2;
	localparam int EP_PPU_LSB = 8;
	localparam int AC_QTY_LSB = 0;
	localparam int AC_MD = 4;
	localparam int AC_ABOVE = 5;
	localparam int AC_VISUAL = 6;
	localparam int AC_AUDIBLE = 7;
	localparam int AC_THR_LSB = 16;
	localparam int INT_GROUP_LSB = 0;
	localparam int INT_LATCH_LSB = 4;
	localparam int INT_PULSE_IN = 8;
	localparam int INT_WD_OPEN = 9;
	localparam int INT_W = 10;

	localparam logic [31:0] RELAY_RESET = 32'h0000_0000;
	localparam logic [31:0] ENERGY_RESET = 32'h000a_0100;

	typedef enum logic [2:0] {
		APO_NORMAL = 3'h0,
		APO_INVERSE = 3'h1,
		APO_LATCHED = 3'h3,
		APO_PULSE = 3'h2,
		APO_PERMANENT = 3'h6
	} apo_shape_type;

	typedef enum logic [1:0] {
		APO_IDLE = 2'h0,
		APO_HIGH = 2'h1,
		APO_GAP = 2'h3
	} apo_pulse_state_type;
endpackage : apo_pkg

// *** src/apo_cfg_if.sv ***
/*
 * Write and read port of the alarm configuration store.
 * Assumes one clock shared by both ends.
 */
`timescale 1ns/1ps
`default_nettype none
interface apo_cfg_if #(parameter int W = 32, parameter int AW = 5);
	logic we;
	logic [AW-1:0] waddr;
	logic [W-1:0] wdata;
	logic [AW-1:0] raddr;
	logic [W-1:0] rdata;
	modport user (output we, output waddr, output wdata, output raddr, input rdata);
	modport store (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : apo_cfg_if
`default_nettype wire

// *** src/apo_cfg_mem.sv ***
/*
 * Configuration store for the individual alarms, one word per alarm.
 * Assumes reads are issued every cycle; data comes out one cycle later.
 */
`timescale 1ns/1ps
`default_nettype none
module apo_cfg_mem #(
	parameter int W = 32,
	parameter int D = 32
) (
	input wire logic clock,
	apo_cfg_if.store port
);
	logic [W-1:0] mem [D];

	always_ff @(posedge clock) begin
		if (port.we) begin
			mem[port.waddr] <= port.wdata;
		end
		port.rdata <= mem[port.raddr];
	end
endmodule : apo_cfg_mem
`default_nettype wire

// *** src/apo_pulse_gen.sv ***
/*
 * One-shot pulse of a length in milliseconds, followed by a low gap of
 * the same length so that back-to-back pulses stay countable.
 * Assumes tick is a one-cycle strobe once per millisecond.
 */
`timescale 1ns/1ps
`default_nettype none
module apo_pulse_gen
	import apo_pkg::*;
(
	input wire logic clock,
	input wire logic rstn,
	input wire logic tick,
	input wire logic trigger,
	input wire logic [15:0] len,
	output logic busy,
	output logic pulse
);
	apo_pulse_state_type state;
	logic [15:0] cnt;

	// Loaded with len and ended one tick after zero, so the pulse never falls short
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			state <= APO_IDLE;
			cnt <= 16'h0000;
		end else begin
			case (state)
				APO_IDLE: begin
					if (trigger) begin
						state <= APO_HIGH;
						cnt <= len;
					end
				end
				APO_HIGH: begin
					if (tick) begin
						if (cnt == 16'h0000) begin
							state <= APO_GAP;
							cnt <= len;
						end else begin
							cnt <= cnt - 16'h0001;
						end
					end
				end
				APO_GAP: begin
					if (tick) begin
						if (cnt == 16'h0000) begin
							state <= APO_IDLE;
						end else begin
							cnt <= cnt - 16'h0001;
						end
					end
				end
				default: begin
					state <= APO_IDLE;
				end
			endcase
		end
	end

	assign busy = (state != APO_IDLE);

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			pulse <= 1'b0;
		end else begin
			pulse <= (state == APO_HIGH) || (state == APO_IDLE && trigger);
		end
	end
endmodule : apo_pulse_gen
`default_nettype wire

// *** verif/apo_top_asserts.sv ***
/* Port checker for apo_top, attached by the bind at the foot.
 * Assumes one clock and the ms prescale handed on by the bind. */
`timescale 1ns/1ps
`default_nettype none
module apo_top_asserts
	import apo_pkg::*;
#(
	parameter int TICK_CYCLES = MS_CYCLES
) (
	input wire logic clock,
	input wire logic rstn,
	input wire logic [7:0] addr,
	input wire logic rd,
	input wire logic [31:0] rdata,
	input wire logic [1:0] tariff_in,
	input wire logic pulse_in,
	input wire logic fault,
	input wire logic supply_ok,
	input wire logic key_press,
	input wire logic energy_pulse,
	input wire logic [3:0] tariff_active,
	input wire logic [3:0] pulse_to_counter,
	input wire logic watchdog_closed,
	input wire logic led_red,
	input wire logic beeper
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rstn);
	int hi_cnt;
	int led_cnt;
	// Run lengths are counted because they exceed what a repetition can unroll
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) hi_cnt <= 0;
		else hi_cnt <= energy_pulse ? hi_cnt + 1 : 0;
	end
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) led_cnt <= 0;
		else led_cnt <= led_red ? led_cnt + 1 : 0;
	end
	a_tariff_decode: assert property ($past(rstn) |-> tariff_active == (4'h1 << $past(tariff_in)))
		else $error("tariff decode wrong");
	a_watchdog_open: assert property ($past(rstn) && ($past(fault) || !$past(supply_ok)) |-> !watchdog_closed)
		else $error("watchdog closed during fault");
	a_ptc_strobe: assert property (|pulse_to_counter |-> $onehot(pulse_to_counter) ##1 pulse_to_counter == 4'h0)
		else $error("counter strobe not one-hot single");
	a_ptc_cause: assert property ($rose(pulse_in) |-> ##[1:3] (|pulse_to_counter))
		else $error("pulse input edge not counted");
	a_epulse_min: assert property ($fell(energy_pulse) |-> hi_cnt >= 10 * TICK_CYCLES)
		else $error("energy pulse shorter than minimum");
	a_beeper_key: assert property (key_press |-> ##2 !beeper)
		else $error("beeper not silenced by key");
	a_led_blink: assert property (led_cnt <= 501 * TICK_CYCLES)
		else $error("led lit longer than half period");
	a_rdata_idle: assert property (!$past(rd) |-> rdata == 32'h0)
		else $error("read data outside read cycle");
	a_state_view: assert property ($past(rd) && $past(addr) == REG_STATE |-> rdata[10:9] == $past(tariff_in))
		else $error("state register tariff field wrong");
	c_epulse: cover property ($rose(energy_pulse));
	c_beep_off: cover property ($fell(beeper));
	c_led: cover property ($rose(led_red));
endmodule : apo_top_asserts
bind apo_top apo_top_asserts #(.TICK_CYCLES(TICK_CYCLES)) u_asserts (.clock(clock), .rstn(rstn),
	.addr(addr), .rd(rd), .rdata(rdata), .tariff_in(tariff_in), .pulse_in(pulse_in),
	.fault(fault), .supply_ok(supply_ok), .key_press(key_press), .energy_pulse(energy_pulse),
	.tariff_active(tariff_active), .pulse_to_counter(pulse_to_counter),
	.watchdog_closed(watchdog_closed), .led_red(led_red), .beeper(beeper));
`default_nettype wire

// *** verif/apo_loads.sv ***
/* Far side: external meter on the pulse input, pulse counter on the
 * energy output, observer of the LED. Assumes the block's clock. */
`timescale 1ns/1ps
`default_nettype none
module apo_loads (
	input wire logic clock,
	input wire logic rstn,
	input wire logic energy_pulse,
	input wire logic led_red,
	input wire logic [7:0] meter_pulses,
	input wire logic meter_go,
	output logic pulse_in,
	output int ep_count,
	output int led_edges
);
	logic [7:0] left;
	logic [1:0] ph;
	logic ep_q;
	logic led_q;
	// Meter pulses are 4 cycles high, 4 low; a real meter is far slower
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			left <= 8'h0;
			ph <= 2'h0;
			pulse_in <= 1'b0;
		end else if (meter_go) begin
			left <= meter_pulses;
		end else if (left != 8'h0) begin
			ph <= ph + 2'h1;
			if (ph == 2'h3) begin
				pulse_in <= !pulse_in;
				if (pulse_in) left <= left - 8'h1;
			end
		end
	end
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			ep_q <= 1'b0;
			led_q <= 1'b0;
			ep_count <= 0;
			led_edges <= 0;
		end else begin
			ep_q <= energy_pulse;
			led_q <= led_red;
			if (energy_pulse && !ep_q) ep_count <= ep_count + 1;
			if (led_red != led_q) led_edges <= led_edges + 1;
		end
	end
endmodule : apo_loads
`default_nettype wire

// *** verif/apo_top_test.sv ***
/* Self-checking bench for apo_top with the far-side model.
 * Assumes a 10-cycle ms prescale so every ms figure shrinks. */
`timescale 1ns/1ps
`default_nettype none
module apo_top_test
	import apo_pkg::*;
;
	typedef struct packed {
		logic [31:0] cfg;
		logic [1:0] tar;
		logic [2:0] exp;
	} apo_row_type;
	// Relay 0 per shape: level idle, while active, after the drop
	apo_row_type rows [6] = '{
		'{32'h0, 2'h0, 3'b101},
		'{32'h1, 2'h1, 3'b010},
		'{32'h0002_0002, 2'h2, 3'b010},
		'{32'he, 2'h3, 3'b111},
		'{32'h6, 2'h0, 3'b000},
		'{32'h3, 2'h1, 3'b011}};
	logic clock, rstn, wr, rd, fault, supply_ok, key_press, pulse_in, meter_go;
	logic energy_pulse, watchdog_closed, led_red, beeper, irq;
	logic [7:0] addr, meter_pulses;
	logic [31:0] wdata, rdata;
	logic [N_QTY*QW-1:0] meas;
	logic [3:0] energy_unit, relay_closed, tariff_active, pulse_to_counter;
	logic [1:0] tariff_in;
	logic [N_GROUPS*QW-1:0] group_time_const;
	int bad_count, cmp_count, cycles, ep_count, led_edges, ptc_n, e0;
	apo_top #(.TICK_CYCLES(10)) dut (.clock(clock), .rstn(rstn), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .meas_value(meas), .max_demand_value('0),
		.energy_unit(energy_unit), .tariff_in(tariff_in), .pulse_in(pulse_in), .fault(fault),
		.supply_ok(supply_ok), .key_press(key_press), .relay_closed(relay_closed),
		.energy_pulse(energy_pulse), .tariff_active(tariff_active),
		.pulse_to_counter(pulse_to_counter), .watchdog_closed(watchdog_closed),
		.led_red(led_red), .beeper(beeper), .group_time_const(group_time_const), .irq(irq));
	apo_loads u_loads (.clock(clock), .rstn(rstn), .energy_pulse(energy_pulse),
		.led_red(led_red), .meter_pulses(meter_pulses), .meter_go(meter_go),
		.pulse_in(pulse_in), .ep_count(ep_count), .led_edges(led_edges));
	task automatic test_done;
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : test_done
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : check
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
	endtask : wr_reg
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		@(posedge clock);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		#1 check(rdata & m, e, "register read");
	endtask : rd_chk
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : wait_cyc
	task automatic set_q(input logic [15:0] v);
		@(posedge clock);
		meas[15:0] <= v;
	endtask : set_q
	task automatic strobe(input logic [3:0] u);
		@(posedge clock);
		energy_unit <= u;
		@(posedge clock);
		energy_unit <= 4'h0;
	endtask : strobe
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	always @(posedge clock) begin
		ptc_n += int'(pulse_to_counter[2]);
		cycles++;
		if (cycles == 40000) begin
			bad_count++;
			$display("mismatch at %0t: run did not finish", $time);
			test_done();
		end
	end
	initial begin
		{rstn, wr, rd, fault, key_press, meter_go, addr, meter_pulses, wdata} = '0;
		{meas, energy_unit, tariff_in} = '0;
		supply_ok = 1'b1;
		@(posedge clock);
		#1 check(32'({relay_closed, watchdog_closed}), 32'h0, "outputs in reset");
		@(posedge clock);
		rstn <= 1'b1;
		wait_cyc(2);
		check(32'(watchdog_closed), 32'h1, "watchdog after reset");
		for (int i = 0; i < 32; i++) begin
			wr_reg(REG_ALARM_INDEX, 32'(i));
			wr_reg(REG_ALARM_CFG, (i == 0) ? 32'h0064_00e0 : 32'hffff_0020);
		end
		wr_reg(REG_GROUP_BASE, 32'h0);
		wait_cyc(40);
		check(32'(relay_closed), 32'hf, "idle relays");
		foreach (rows[i]) begin
			wr_reg(REG_RELAY_BASE, rows[i].cfg);
			tariff_in <= rows[i].tar;
			wait_cyc(4);
			check(32'(tariff_active), 32'h1 << rows[i].tar, "tariff");
			check(32'(relay_closed[0]), 32'(rows[i].exp[2]), "relay idle");
			set_q(16'd200);
			wait_cyc(100);
			check(32'(relay_closed[0]), 32'(rows[i].exp[1]), "relay active");
			set_q(16'd50);
			wait_cyc(150);
			check(32'(relay_closed[0]), 32'(rows[i].exp[0]), "relay after");
		end
		rd_chk(REG_STATE, 32'h600, 32'h200);
		wr_reg(REG_LATCH_CLEAR, 32'h1);
		wait_cyc(4);
		check(32'(relay_closed[0]), 32'h0, "latch cleared");
		rd_chk(REG_INT_STATUS, 32'h11, 32'h11);
		wr_reg(REG_INT_ENABLE, 32'h1);
		wait_cyc(1);
		check(32'(irq), 32'h1, "irq enabled");
		wr_reg(REG_INT_ENABLE, 32'h0);
		wait_cyc(1);
		check(32'(irq), 32'h0, "irq masked");
		wr_reg(REG_INT_ENABLE, 32'h1);
		wr_reg(REG_INT_CLEAR, 32'h1);
		wait_cyc(1);
		check(32'(irq), 32'h0, "irq cleared");
		rd_chk(REG_INT_STATUS, 32'h1, 32'h0);
		wr_reg(REG_RELAY_BASE, 32'h0);
		wr_reg(REG_GROUP_BASE, 32'h0014_000a);
		set_q(16'd200);
		wait_cyc(60);
		check(32'(relay_closed[0]), 32'h1, "group delay running");
		rd_chk(REG_ALARM_ACTIVE, 32'h1, 32'h1);
		wait_cyc(100);
		check(32'(relay_closed[0]), 32'h0, "group delay over");
		check(32'(beeper), 32'h1, "beeper on");
		@(posedge clock);
		key_press <= 1'b1;
		@(posedge clock);
		key_press <= 1'b0;
		wait_cyc(3);
		check(32'(beeper), 32'h0, "beeper silenced");
		e0 = led_edges;
		wait_cyc(10100);
		check(32'(led_edges - e0 >= 2), 32'h1, "led blinking");
		set_q(16'd90);
		wait_cyc(80);
		rd_chk(REG_ALARM_ACTIVE, 32'h1, 32'h1);
		set_q(16'd80);
		wait_cyc(80);
		rd_chk(REG_ALARM_ACTIVE, 32'h1, 32'h0);
		check(32'({led_red, relay_closed[0]}), 32'h1, "led off relay closed");
		wr_reg(REG_TCONST_BASE + 8'h4, 32'h1234);
		wait_cyc(2);
		check(32'(group_time_const[31:16]), 32'h1234, "time constant");
		e0 = ep_count;
		wr_reg(REG_ENERGY_PULSE, 32'h0000_0309);
		tariff_in <= 2'h2;
		strobe(4'h2);
		wait_cyc(800);
		check(32'(ep_count - e0), 32'h3, "energy pulses");
		strobe(4'h1);
		tariff_in <= 2'h1;
		strobe(4'h2);
		wait_cyc(300);
		check(32'(ep_count - e0), 32'h3, "pulses outside tariff");
		wr_reg(REG_CTRL, 32'h4);
		meter_pulses <= 8'h5;
		meter_go <= 1'b1;
		@(posedge clock);
		meter_go <= 1'b0;
		wait_cyc(60);
		check(32'(ptc_n), 32'h5, "routed pulses");
		rd_chk(REG_PULSE_COUNT, 32'hffff_ffff, 32'h5);
		wr_reg(REG_CTRL, 32'h5);
		wait_cyc(3);
		check(32'(watchdog_closed), 32'h0, "watchdog test");
		rd_chk(REG_INT_STATUS, 32'h200, 32'h200);
		wr_reg(REG_CTRL, 32'h4);
		wait_cyc(3);
		check(32'(watchdog_closed), 32'h1, "watchdog normal");
		@(posedge clock);
		fault <= 1'b1;
		wait_cyc(3);
		check(32'(watchdog_closed), 32'h0, "watchdog fault");
		@(posedge clock);
		fault <= 1'b0;
		rd_chk(8'hfc, 32'hffff_ffff, 32'h0);
		test_done();
	end
endmodule : apo_top_test
`default_nettype wire
